// *** verilog/supercap_learn_balance_ctrl.v ***
// supervisory control: learning, health, charge modes and balancing
//
// What this block does
// - learn: charge, discharge, charge, discharge, compute, pick voltage
// - learn starts each interval and at once on host command
// - unsealed with interval 250 means a ten-minute test interval
// - capacitance is I*dt/dV; ESR is load step voltage over I
// - capacitance loads initial value, updates and saves after each learn
// - charge percent is (V-Vmin)/(Vchg-Vmin)
// - learn start sets active, clears passed; completion sets passed
// - learn length follows learn duration; first learn waits one interval
// - phase timer per phase; timeout flags set, cleared next learn
// - new charging voltage chosen from learned capacitance
// - nominal level clears all health flags
// - max level and too little energy sets fail flag
// - fault output when a masked-in health flag sets
// - load enable high during ESR measurement; first ESR kept once
// - reported ESR is measured plus offset; design ESR unused
// - discharge on current below -threshold; exit after 1 s above charge
// - charge on current above threshold; exit after 1 s below discharge
// - balancing inactive until command 0x21 received
// - one bypass output per capacitor, bottom on its own output
// - bypass caps above threshold if spread large; off while measuring
// - stop below min spread or discharge; restart at restart spread
// - stack mode forces every bypass output off
// - refresh all voltages each second with one strobe; stack mode gates only the bypass
`timescale 1ns/100ps
`include "supercap_regs.vh"
module supercap_learn_balance_ctrl #(
	parameter integer NCAP = 5,
	parameter integer SEC_CYCLES = `SECOND_CYCLES,
	parameter integer MEAS_CYCLES = 16
) (
	// clock and reset
	input wire ref_clk_i,
	input wire rst_i,
	// configuration
	input wire unsealed_i,
	input wire stack_mode_i,
	input wire [2:0] cap_count_i,
	input wire [7:0] learn_interval_i,
	input wire [15:0] learn_duration_i,
	input wire [15:0] max_charge_time_i,
	input wire [15:0] max_discharge_time_i,
	input wire [15:0] learn_max_mv_i,
	input wire [15:0] min_voltage_mv_i,
	input wire [15:0] initial_cap_i,
	input wire [15:0] esr_offset_i,
	input wire [15:0] cap_nominal_min_i,
	input wire [15:0] cap_level_a_min_i,
	input wire [15:0] cap_level_b_min_i,
	input wire [15:0] cap_required_i,
	input wire [15:0] vchg_nominal_mv_i,
	input wire [15:0] vchg_a_mv_i,
	input wire [15:0] vchg_b_mv_i,
	input wire [15:0] vchg_max_mv_i,
	input wire [2:0] fault_mask_i,
	input wire signed [15:0] chg_threshold_i,
	input wire signed [15:0] dsg_threshold_i,
	input wire [15:0] balance_voltage_threshold_i,
	input wire [15:0] balance_min_spread_i,
	input wire [15:0] balance_restart_spread_i,
	input wire full_charge_flag_i,
	// host command
	input wire cmd_valid_i,
	input wire [7:0] cmd_code_i,
	input wire learn_cmd_i,
	// measurement front end
	input wire [15:0] stack_mv_i,
	input wire [16*NCAP-1:0] cap_mv_i,
	input wire signed [15:0] avg_current_i,
	// learn results and status
	output reg [15:0] capacitance_o,
	output reg cap_save_o,
	output reg [15:0] esr_mohm_o,
	output reg [15:0] initial_esr_o,
	output reg [6:0] relative_charge_percent_o,
	output reg [1:0] chg_level_o,
	output reg learning_active_flag_o,
	output reg learn_passed_flag_o,
	output reg learn_discharge_timeout_flag_o,
	output reg learn_charge_timeout_flag_o,
	output reg health_low_flag_o,
	output reg health_warning_flag_o,
	output reg health_fail_flag_o,
	output reg fault_o,
	output reg learn_load_enable_o,
	output reg charger_learn_o,
	output reg discharge_flag_o,
	output reg charge_mode_o,
	output reg measure_strobe_o,
	output reg [NCAP-2:0] upper_bypass_o,
	output reg bottom_cap_bypass_out_o
);
	// ------------------------------------------------------------
	// one-second tick and interval timer
	// ------------------------------------------------------------
	localparam [31:0] SEC_LAST = SEC_CYCLES - 1;
	reg [31:0] sec_cnt;
	reg sec_tick;
	reg [31:0] interval_s;
	reg [31:0] int_cnt;
	reg learn_req;
	reg [15:0] phase_s;

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			sec_cnt <= 32'h00000000;
			sec_tick <= 1'b0;
		end else begin
			sec_tick <= (sec_cnt == SEC_LAST);
			sec_cnt <= (sec_cnt == SEC_LAST) ? 32'h00000000 : sec_cnt + 1'b1;
		end
	end

	always @* begin
		if (unsealed_i && learn_interval_i == `TEST_INTERVAL_CODE)
			interval_s = `TEST_INTERVAL_S;
		else
			interval_s = {24'h000000, learn_interval_i} * 32'd3600;
	end

	// ------------------------------------------------------------
	// learn sequencer
	// ------------------------------------------------------------
	localparam [7:0] S_IDLE = 8'h01;
	localparam [7:0] S_CHG1 = 8'h02;
	localparam [7:0] S_DSG1 = 8'h04;
	localparam [7:0] S_CHG2 = 8'h08;
	localparam [7:0] S_DSG2 = 8'h10;
	localparam [7:0] S_CALC = 8'h20;
	localparam [7:0] S_PICK = 8'h40;
	reg [7:0] state;
	reg [15:0] v_a;
	reg [15:0] v_c;
	reg [15:0] t_c;
	reg [15:0] esr_meas;
	reg esr_stored;
	reg step_pending;
	reg [47:0] cap_calc;
	reg [1:0] next_level;
	reg [15:0] dv;
	reg [31:0] esr_calc;

	always @* begin
		dv = v_c - stack_mv_i;
		if (dv == 16'h0000)
			cap_calc = 48'h0;
		else
			cap_calc = ({32'h0, avg_current_i[15] ? -avg_current_i
				: avg_current_i} * {32'h0, phase_s - t_c}) / {32'h0, dv};
		// widened so the step times 1000 does not wrap
		if (avg_current_i == 16'sh0000)
			esr_calc = 32'h00000000;
		else
			esr_calc = ({16'h0000, esr_meas} * 32'd1000) /
				{16'h0000, avg_current_i[15] ? -avg_current_i
				: avg_current_i};
		if (capacitance_o >= cap_nominal_min_i)
			next_level = `CHG_NOMINAL;
		else if (capacitance_o >= cap_level_a_min_i)
			next_level = `CHG_LEVEL_A;
		else if (capacitance_o >= cap_level_b_min_i)
			next_level = `CHG_LEVEL_B;
		else
			next_level = `CHG_MAX;
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			state <= S_IDLE;
			int_cnt <= 32'h00000000;
			learn_req <= 1'b0;
			phase_s <= 16'h0000;
			v_a <= 16'h0000;
			v_c <= 16'h0000;
			t_c <= 16'h0000;
			esr_meas <= 16'h0000;
			esr_stored <= 1'b0;
			step_pending <= 1'b0;
			capacitance_o <= 16'h0000;
			cap_save_o <= 1'b0;
			esr_mohm_o <= 16'h0000;
			initial_esr_o <= `RST_ESR_INIT;
			chg_level_o <= `CHG_NOMINAL;
			learning_active_flag_o <= 1'b0;
			learn_passed_flag_o <= 1'b0;
			learn_discharge_timeout_flag_o <= 1'b0;
			learn_charge_timeout_flag_o <= 1'b0;
			health_low_flag_o <= 1'b0;
			health_warning_flag_o <= 1'b0;
			health_fail_flag_o <= 1'b0;
			fault_o <= 1'b0;
			learn_load_enable_o <= 1'b0;
			charger_learn_o <= 1'b0;
		end else begin
			cap_save_o <= 1'b0;
			if (learning_active_flag_o == 1'b0 && capacitance_o == 16'h0000)
				capacitance_o <= initial_cap_i;
			// interval counting starts at reset so first learn waits
			if (sec_tick && state == S_IDLE) begin
				if (int_cnt + 1'b1 >= interval_s) begin
					int_cnt <= 32'h00000000;
					learn_req <= 1'b1;
				end else begin
					int_cnt <= int_cnt + 1'b1;
				end
			end
			if (learn_cmd_i)
				learn_req <= 1'b1;
			if (sec_tick)
				phase_s <= phase_s + 1'b1;
			case (state)
			S_IDLE: begin
				if (learn_req) begin
					learn_req <= 1'b0;
					learning_active_flag_o <= 1'b1;
					learn_passed_flag_o <= 1'b0;
					learn_discharge_timeout_flag_o <= 1'b0;
					learn_charge_timeout_flag_o <= 1'b0;
					phase_s <= 16'h0000;
					charger_learn_o <= 1'b1;
					state <= S_CHG1;
				end
			end
			S_CHG1, S_CHG2: begin
				if (phase_s > max_charge_time_i)
					learn_charge_timeout_flag_o <= 1'b1;
				if (stack_mv_i >= learn_max_mv_i) begin
					charger_learn_o <= 1'b0;
					learn_load_enable_o <= 1'b1;
					phase_s <= 16'h0000;
					v_a <= stack_mv_i;
					step_pending <= 1'b1;
					state <= (state == S_CHG1) ? S_DSG1 : S_DSG2;
				end
			end
			S_DSG1, S_DSG2: begin
				if (step_pending && sec_tick) begin
					step_pending <= 1'b0;
					esr_meas <= (v_a - stack_mv_i); // step, scaled by I below
					v_c <= stack_mv_i;
					t_c <= phase_s;
				end
				if (phase_s > max_discharge_time_i)
					learn_discharge_timeout_flag_o <= 1'b1;
				if (!step_pending && (stack_mv_i <= min_voltage_mv_i
						|| phase_s >= learn_duration_i)) begin
					learn_load_enable_o <= 1'b0;
					if (state == S_DSG1) begin
						// restart phase time for the second charge; only the last pass keeps it for the calc
						phase_s <= 16'h0000;
						charger_learn_o <= 1'b1;
						state <= S_CHG2;
					end else begin
						state <= S_CALC;
					end
				end
			end
			S_CALC: begin
				capacitance_o <= cap_calc[15:0];
				cap_save_o <= 1'b1;
				if (avg_current_i != 16'sh0000)
					esr_meas <= esr_calc[15:0];
				state <= S_PICK;
			end
			S_PICK: begin
				esr_mohm_o <= esr_meas + esr_offset_i;
				if (!esr_stored) begin
					esr_stored <= 1'b1;
					initial_esr_o <= esr_meas;
				end
				chg_level_o <= next_level;
				case (next_level)
				`CHG_NOMINAL: begin
					health_low_flag_o <= 1'b0;
					health_warning_flag_o <= 1'b0;
					health_fail_flag_o <= 1'b0;
				end
				`CHG_MAX: begin
					health_warning_flag_o <= 1'b1;
					if (capacitance_o < cap_required_i)
						health_fail_flag_o <= 1'b1;
				end
				default: health_low_flag_o <= 1'b1;
				endcase
				if ((next_level == `CHG_MAX && (fault_mask_i[`FMASK_WARN] ||
					(capacitance_o < cap_required_i &&
					fault_mask_i[`FMASK_FAIL]))) ||
					(next_level != `CHG_NOMINAL && next_level != `CHG_MAX
					&& fault_mask_i[`FMASK_LOW]))
					fault_o <= 1'b1;
				else if (next_level == `CHG_NOMINAL)
					fault_o <= 1'b0;
				learning_active_flag_o <= 1'b0;
				learn_passed_flag_o <= 1'b1;
				state <= S_IDLE;
			end
			default: state <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// relative charge and charge/discharge modes
	// ------------------------------------------------------------
	reg [15:0] vchg_sel;
	reg [31:0] relative_charge_percent_calc;
	wire dsg_exit;
	wire chg_exit;

	always @* begin
		case (chg_level_o)
		`CHG_LEVEL_A: vchg_sel = vchg_a_mv_i;
		`CHG_LEVEL_B: vchg_sel = vchg_b_mv_i;
		`CHG_MAX: vchg_sel = vchg_max_mv_i;
		default: vchg_sel = vchg_nominal_mv_i;
		endcase
		if (stack_mv_i <= min_voltage_mv_i || vchg_sel <= min_voltage_mv_i)
			relative_charge_percent_calc = 32'h0;
		else
			relative_charge_percent_calc = ({16'h0, stack_mv_i - min_voltage_mv_i} * 32'd100)
				/ {16'h0, vchg_sel - min_voltage_mv_i};
	end

	hold_timer #(.COUNT(SEC_CYCLES), .W(32)) u_dsg_exit (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.cond_i(avg_current_i > chg_threshold_i),
		.expired_o(dsg_exit)
	);

	hold_timer #(.COUNT(SEC_CYCLES), .W(32)) u_chg_exit (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.cond_i(avg_current_i < -dsg_threshold_i),
		.expired_o(chg_exit)
	);

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			relative_charge_percent_o <= 7'h00;
			discharge_flag_o <= 1'b0;
			charge_mode_o <= 1'b0;
		end else begin
			relative_charge_percent_o <= (relative_charge_percent_calc > 32'd100) ? 7'h64 :
				relative_charge_percent_calc[6:0];
			if (avg_current_i < -dsg_threshold_i)
				discharge_flag_o <= 1'b1;
			else if (dsg_exit)
				discharge_flag_o <= 1'b0;
			if (avg_current_i > chg_threshold_i)
				charge_mode_o <= 1'b1;
			else if (chg_exit)
				charge_mode_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// measurement schedule and balancing
	// ------------------------------------------------------------
	reg bal_enabled;
	reg bal_run;
	reg [7:0] meas_cnt;
	reg [15:0] vmax;
	reg [15:0] vmin;
	reg [15:0] spread;
	reg [NCAP-1:0] sel;
	integer i;

	always @* begin
		vmax = 16'h0000;
		vmin = 16'hFFFF;
		for (i = 0; i < NCAP; i = i + 1) begin
			if (i < cap_count_i) begin
				if (cap_mv_i[16*i +: 16] > vmax)
					vmax = cap_mv_i[16*i +: 16];
				if (cap_mv_i[16*i +: 16] < vmin)
					vmin = cap_mv_i[16*i +: 16];
			end
		end
		spread = (vmax > vmin) ? vmax - vmin : 16'h0000;
		for (i = 0; i < NCAP; i = i + 1)
			sel[i] = (i < cap_count_i) &&
				(cap_mv_i[16*i +: 16] > balance_voltage_threshold_i);
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			bal_enabled <= 1'b0;
			bal_run <= 1'b0;
			meas_cnt <= 8'h00;
			measure_strobe_o <= 1'b0;
			upper_bypass_o <= {(NCAP-1){1'b0}};
			bottom_cap_bypass_out_o <= 1'b0;
		end else begin
			if (cmd_valid_i && cmd_code_i == `CMD_BALANCE_ENABLE)
				bal_enabled <= 1'b1;
			measure_strobe_o <= sec_tick;
			if (sec_tick)
				meas_cnt <= MEAS_CYCLES[7:0];
			else if (meas_cnt != 8'h00)
				meas_cnt <= meas_cnt - 1'b1;
			if (spread < balance_min_spread_i || discharge_flag_o)
				bal_run <= 1'b0;
			else if (spread >= balance_restart_spread_i &&
					(charge_mode_o || full_charge_flag_i))
				bal_run <= 1'b1;
			if (!bal_enabled || stack_mode_i || !bal_run || sec_tick ||
					meas_cnt != 8'h00) begin
				upper_bypass_o <= {(NCAP-1){1'b0}};
				bottom_cap_bypass_out_o <= 1'b0;
			end else if (meas_cnt == 8'h00) begin
				upper_bypass_o <= sel[NCAP-1:1];
				bottom_cap_bypass_out_o <= sel[0];
			end
		end
	end
endmodule // supercap_learn_balance_ctrl

// *** verilog/supercap_regs.vh ***
// constants shared by the super-capacitor supervisory controller
`ifndef SUPERCAP_REGS_VH
`define SUPERCAP_REGS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define SECOND_NS 1000000000
`define SECOND_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)
`define TEST_INTERVAL_MIN 10
`define TEST_INTERVAL_S (`TEST_INTERVAL_MIN * 60)
`define TEST_INTERVAL_CODE 8'hFA

// ----------------------------------------------------------------
// commands
// ----------------------------------------------------------------
`define CMD_BALANCE_ENABLE 8'h21

// ----------------------------------------------------------------
// charging voltage level codes
// ----------------------------------------------------------------
`define CHG_NOMINAL 2'h0
`define CHG_LEVEL_A 2'h1
`define CHG_LEVEL_B 2'h2
`define CHG_MAX 2'h3

// ----------------------------------------------------------------
// fault mask bit positions
// ----------------------------------------------------------------
`define FMASK_LOW 0
`define FMASK_WARN 1
`define FMASK_FAIL 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_ESR_INIT 16'h0000

`endif

// *** verilog/hold_timer.v ***
// qualification timer: counts while a condition holds, restarts when not
`timescale 1ns/100ps
module hold_timer #(
	parameter integer COUNT = 200000000,
	parameter integer W = 28
) (
	// clock and reset
	input wire ref_clk_i,
	input wire rst_i,
	// condition in, expiry out
	input wire cond_i,
	output reg expired_o
);
	reg [W-1:0] cnt;

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			cnt <= {W{1'b0}};
			expired_o <= 1'b0;
		end else if (!cond_i) begin
			cnt <= {W{1'b0}};
			expired_o <= 1'b0;
		end else if (cnt > COUNT[W-1:0]) begin
			expired_o <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end
endmodule // hold_timer

// *** tb/supercap_learn_balance_ctrl_checker.sv ***
// assertion checker for the super-capacitor supervisory controller
`timescale 1ns/100ps
`include "supercap_regs.vh"
module supercap_learn_balance_ctrl_checker #(
	parameter integer NCAP = 5,
	parameter integer SEC_CYCLES = 100
) (
	// clock, reset and watched inputs
	input wire ref_clk_i,
	input wire rst_i,
	input wire stack_mode_i,
	input wire [2:0] fault_mask_i,
	input wire signed [15:0] chg_threshold_i,
	input wire signed [15:0] dsg_threshold_i,
	input wire cmd_valid_i,
	input wire [7:0] cmd_code_i,
	input wire learn_cmd_i,
	input wire signed [15:0] avg_current_i,
	// watched outputs
	input wire cap_save_o,
	input wire [1:0] chg_level_o,
	input wire learning_active_flag_o,
	input wire learn_passed_flag_o,
	input wire learn_discharge_timeout_flag_o,
	input wire learn_charge_timeout_flag_o,
	input wire health_low_flag_o,
	input wire health_warning_flag_o,
	input wire health_fail_flag_o,
	input wire fault_o,
	input wire learn_load_enable_o,
	input wire charger_learn_o,
	input wire discharge_flag_o,
	input wire charge_mode_o,
	input wire measure_strobe_o,
	input wire [NCAP-2:0] upper_bypass_o,
	input wire bottom_cap_bypass_out_o
);
// --------
// helper logic
// --------
reg bal_on;
reg [31:0] above_cnt;
reg [31:0] below_cnt;
wire [2:0] hflags = {health_fail_flag_o, health_warning_flag_o,
	health_low_flag_o};
wire bypass_any = |{upper_bypass_o, bottom_cap_bypass_out_o};
always @(posedge ref_clk_i) begin
	if (rst_i) begin
		bal_on <= 1'b0;
		above_cnt <= 32'h0;
		below_cnt <= 32'h0;
	end else begin
		if (cmd_valid_i && cmd_code_i == `CMD_BALANCE_ENABLE)
			bal_on <= 1'b1;
		above_cnt <= (avg_current_i > chg_threshold_i) ? above_cnt + 1 : 0;
		below_cnt <= (avg_current_i < -dsg_threshold_i) ? below_cnt + 1 : 0;
	end
end
// --------
// properties
// --------
default clocking cb @(posedge ref_clk_i); endclocking
default disable iff (rst_i);
sequence s_learn_end;
	$fell(learning_active_flag_o);
endsequence
property p_learn_start;
	learn_cmd_i && !learning_active_flag_o |-> ##[1:3] learning_active_flag_o;
endproperty
a_learn_start: assert property (p_learn_start) else $error("no learn start");
property p_start_clear;
	$rose(learning_active_flag_o) |-> !learn_passed_flag_o &&
		!learn_charge_timeout_flag_o && !learn_discharge_timeout_flag_o;
endproperty
a_start_clear: assert property (p_start_clear) else $error("flags kept");
property p_end_pass;
	s_learn_end |-> learn_passed_flag_o && $past(cap_save_o);
endproperty
a_end_pass: assert property (p_end_pass) else $error("bad learn end");
property p_phases;
	learn_load_enable_o || charger_learn_o |->
		learning_active_flag_o && !(learn_load_enable_o && charger_learn_o);
endproperty
a_phases: assert property (p_phases) else $error("bad learn phase");
property p_nominal;
	s_learn_end ##0 chg_level_o == `CHG_NOMINAL |-> hflags == 3'h0;
endproperty
a_nominal: assert property (p_nominal) else $error("health kept");
property p_max_warn;
	s_learn_end ##0 chg_level_o == `CHG_MAX |-> health_warning_flag_o;
endproperty
a_max_warn: assert property (p_max_warn) else $error("no warning");
property p_fault;
	s_learn_end ##0 |(hflags & fault_mask_i) |-> fault_o;
endproperty
a_fault: assert property (p_fault) else $error("no fault output");
property p_dsg_entry;
	avg_current_i < -dsg_threshold_i |=> discharge_flag_o;
endproperty
a_dsg_entry: assert property (p_dsg_entry) else $error("no discharge");
property p_dsg_exit;
	$fell(discharge_flag_o) |-> above_cnt >= SEC_CYCLES;
endproperty
a_dsg_exit: assert property (p_dsg_exit) else $error("early exit");
property p_chg_exit;
	$fell(charge_mode_o) |-> below_cnt >= SEC_CYCLES;
endproperty
a_chg_exit: assert property (p_chg_exit) else $error("early exit");
property p_bal_gate;
	bypass_any |-> bal_on && !$past(stack_mode_i);
endproperty
a_bal_gate: assert property (p_bal_gate) else $error("bypass on");
property p_meas_off;
	measure_strobe_o |-> !bypass_any ##1 !bypass_any [*8];
endproperty
a_meas_off: assert property (p_meas_off) else $error("bypass on");
endmodule // supercap_learn_balance_ctrl_checker

// *** tb/supercap_far_side.sv ***
// far-side model: learn charger, constant-current load and stack voltage
`timescale 1ns/100ps
module supercap_far_side (
	// clock and reset
	input wire ref_clk_i,
	input wire rst_i,
	// controls from the block
	input wire charger_learn_i,
	input wire load_enable_i,
	input wire [15:0] esr_step_i,
	// stack response
	output reg [15:0] stack_mv_o,
	output reg signed [15:0] load_current_o
);
reg load_d;
always @(posedge ref_clk_i) begin
	load_d <= load_enable_i;
	if (rst_i) begin
		stack_mv_o <= 16'h0BB8;
		load_current_o <= 16'sh0000;
	end else if (charger_learn_i) begin
		stack_mv_o <= stack_mv_o + 16'h0014;
		load_current_o <= 16'sh01F4;
	end else if (load_enable_i) begin
		// resistive step when the load lands, then a linear slope
		stack_mv_o <= stack_mv_o - (load_d ? 16'h0002 : esr_step_i);
		load_current_o <= -16'sh03E8;
	end else
		load_current_o <= 16'sh0000;
end
endmodule // supercap_far_side

// *** tb/supercap_learn_balance_ctrl_tb_top.sv ***
// self-checking bench for the super-capacitor supervisory controller
`timescale 1ns/100ps
`include "supercap_regs.vh"
module supercap_learn_balance_ctrl_tb_top;
// --------
// signals
// --------
localparam integer NCAP = 5;
localparam integer SEC_CYCLES = 100;
localparam integer MEAS_CYCLES = 16;
reg ref_clk_i = 1'b0;
reg rst_i = 1'b1;
reg unsealed_i, stack_mode_i, full_charge_flag_i, cmd_valid_i, learn_cmd_i;
reg cur_sel;
reg [2:0] cap_count_i, fault_mask_i;
reg [7:0] learn_interval_i, cmd_code_i;
reg [15:0] learn_duration_i, max_charge_time_i, max_discharge_time_i;
reg [15:0] learn_max_mv_i, min_voltage_mv_i, initial_cap_i, esr_offset_i;
reg [15:0] cap_nominal_min_i, cap_level_a_min_i, cap_level_b_min_i;
reg [15:0] cap_required_i, vchg_nominal_mv_i, vchg_a_mv_i, vchg_b_mv_i;
reg [15:0] vchg_max_mv_i, balance_voltage_threshold_i, esr_step, esr1, init1;
reg [15:0] balance_min_spread_i, balance_restart_spread_i;
reg signed [15:0] chg_threshold_i, dsg_threshold_i, tb_cur;
reg [16*NCAP-1:0] cap_mv_i;
wire [15:0] stack_mv_i, capacitance_o, esr_mohm_o, initial_esr_o;
wire signed [15:0] far_cur;
wire signed [15:0] avg_current_i = cur_sel ? far_cur : tb_cur;
wire cap_save_o, learning_active_flag_o, learn_passed_flag_o;
wire learn_discharge_timeout_flag_o, learn_charge_timeout_flag_o;
wire health_low_flag_o, health_warning_flag_o, health_fail_flag_o;
wire fault_o, learn_load_enable_o, charger_learn_o, discharge_flag_o;
wire charge_mode_o, measure_strobe_o, bottom_cap_bypass_out_o;
wire [6:0] relative_charge_percent_o;
wire [1:0] chg_level_o;
wire [NCAP-2:0] upper_bypass_o;
wire [4:0] bp = {upper_bypass_o, bottom_cap_bypass_out_o};
integer err_count = 0, compares = 0, saves = 0, i, rs;
// --------
// design and far side
// --------
supercap_learn_balance_ctrl #(.NCAP(NCAP), .SEC_CYCLES(SEC_CYCLES),
	.MEAS_CYCLES(MEAS_CYCLES)) supercap_learn_balance_ctrl_inst (.*);
supercap_far_side supercap_far_side_inst (.ref_clk_i(ref_clk_i),
	.rst_i(rst_i), .charger_learn_i(charger_learn_o),
	.load_enable_i(learn_load_enable_o), .esr_step_i(esr_step),
	.stack_mv_o(stack_mv_i), .load_current_o(far_cur));
always #2.5 ref_clk_i = ~ref_clk_i;
always @(posedge ref_clk_i) if (cap_save_o === 1'b1) saves = saves + 1;
// --------
// tasks
// --------
task step(input integer n);
	begin
		repeat (n) @(posedge ref_clk_i);
		#1;
	end
endtask
task chk(input [31:0] seen, input [31:0] exp);
	begin
		compares = compares + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	end
endtask
task end_of_test;
	begin
		$display("compares %0d, err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
endtask
task give_up;
	begin
		err_count = err_count + 1;
		end_of_test;
	end
endtask
task wait_meas;
	begin
		for (i = 0; i < 300 && measure_strobe_o !== 1'b1; i = i + 1)
			step(1);
		if (i == 300) give_up;
		step(MEAS_CYCLES + 4);
	end
endtask
task learn(input [15:0] nom, lva, lvb, input [1:0] lvl,
	input [2:0] m, e, input f);
	integer s;
	begin
		cap_nominal_min_i = nom;
		cap_level_a_min_i = lva;
		cap_level_b_min_i = lvb;
		cap_required_i = lvb;
		s = saves;
		learn_cmd_i = 1'b1;
		step(1);
		learn_cmd_i = 1'b0;
		step(2);
		chk(learning_active_flag_o, 1);
		chk(learn_passed_flag_o, 0);
		for (i = 0; i < 2000 && learn_passed_flag_o !== 1'b1; i = i + 1)
			step(1);
		if (i == 2000) give_up;
		chk(learning_active_flag_o, 0);
		chk(saves - s, 1);
		chk(capacitance_o != initial_cap_i, 1);
		chk(chg_level_o, lvl);
		chk(bp[0] | hflags_fn(m), e);
		chk(fault_o, f);
		chk(learn_charge_timeout_flag_o | learn_discharge_timeout_flag_o, 0);
		$display("learn test done, level %0d", lvl);
	end
endtask
function [2:0] hflags_fn(input [2:0] m);
	hflags_fn = {health_fail_flag_o, health_warning_flag_o,
		health_low_flag_o} & m;
endfunction
task bal(input stk, input signed [15:0] cur, input [15:0] hi,
	input [4:0] exp);
	begin
		stack_mode_i = stk;
		tb_cur = cur;
		cap_mv_i = {16'h07D0, hi, 16'h07D0, 16'h07D0, hi};
		wait_meas;
		chk(bp, exp);
	end
endtask
// --------
// sequence
// --------
initial begin
	unsealed_i = 1'b1;
	stack_mode_i = 1'b0;
	full_charge_flag_i = 1'b0;
	cmd_valid_i = 1'b0;
	cmd_code_i = 8'h00;
	learn_cmd_i = 1'b0;
	cur_sel = 1'b0;
	tb_cur = 16'sh0000;
	esr_step = 16'h0064;
	cap_count_i = 3'h5;
	fault_mask_i = 3'h0;
	learn_interval_i = `TEST_INTERVAL_CODE;
	learn_duration_i = 16'h0001;
	max_charge_time_i = 16'h0064;
	max_discharge_time_i = 16'h0064;
	learn_max_mv_i = 16'h1388;
	min_voltage_mv_i = 16'h07D0;
	initial_cap_i = 16'h1234;
	esr_offset_i = 16'h000A;
	{cap_nominal_min_i, cap_level_a_min_i} = 32'h0;
	{cap_level_b_min_i, cap_required_i} = 32'h0;
	{vchg_nominal_mv_i, vchg_a_mv_i} = {16'h1388, 16'h1450};
	{vchg_b_mv_i, vchg_max_mv_i} = {16'h1518, 16'h15E0};
	{chg_threshold_i, dsg_threshold_i} = {16'sh0064, 16'sh0064};
	balance_voltage_threshold_i = 16'h0834;
	balance_min_spread_i = 16'h0032;
	balance_restart_spread_i = 16'h0064;
	cap_mv_i = {NCAP{16'h07D0}};
	step(2);
	rst_i = 1'b0;
	step(3);
	chk(capacitance_o, initial_cap_i);
	tb_cur = -16'sh00C8;
	step(2);
	chk(discharge_flag_o, 1);
	tb_cur = 16'sh00C8;
	step(2);
	chk(charge_mode_o, 1);
	step(SEC_CYCLES / 2);
	tb_cur = 16'sh0000;
	step(1);
	tb_cur = 16'sh00C8;
	step(SEC_CYCLES - 10);
	chk(discharge_flag_o, 1);
	step(20);
	chk(discharge_flag_o, 0);
	tb_cur = -16'sh00C8;
	step(SEC_CYCLES - 10);
	chk(charge_mode_o, 1);
	step(20);
	chk(charge_mode_o, 0);
	$display("mode test done");
	cur_sel = 1'b1;
	learn(16'h0, 16'h0, 16'h0, `CHG_NOMINAL, 3'h7, 3'h0, 0);
	esr1 = esr_mohm_o;
	init1 = initial_esr_o;
	esr_step = 16'h00C8;
	fault_mask_i = 3'h1;
	learn(16'hFFFF, 16'h0, 16'h0, `CHG_LEVEL_A, 3'h7, 3'h1, 1);
	chk(initial_esr_o, init1);
	chk(esr_mohm_o != esr1, 1);
	chk(esr_mohm_o >= esr_step + esr_offset_i, 1);
	learn(16'hFFFF, 16'hFFFF, 16'h0, `CHG_LEVEL_B, 3'h1, 3'h1, 1);
	learn(16'hFFFF, 16'hFFFF, 16'hFFFF, `CHG_MAX, 3'h6, 3'h6, 1);
	learn(16'h0, 16'h0, 16'h0, `CHG_NOMINAL, 3'h7, 3'h0, 0);
	wait_meas;
	rs = (stack_mv_i - min_voltage_mv_i) * 100 / 3000;
	chk((rs > 100 ? 100 : rs) - relative_charge_percent_o + 1 <= 2, 1);
	cur_sel = 1'b0;
	tb_cur = 16'sh00C8;
	step(2 * SEC_CYCLES);
	bal(0, 16'sh00C8, 16'h08FC, 5'h00);
	cmd_code_i = `CMD_BALANCE_ENABLE;
	cmd_valid_i = 1'b1;
	step(1);
	cmd_valid_i = 1'b0;
	bal(0, 16'sh00C8, 16'h08FC, 5'h09);
	bal(1, 16'sh00C8, 16'h08FC, 5'h00);
	bal(0, 16'sh00C8, 16'h08FC, 5'h09);
	bal(0, 16'sh00C8, 16'h07EE, 5'h00);
	bal(0, 16'sh00C8, 16'h0820, 5'h00);
	bal(0, 16'sh00C8, 16'h08FC, 5'h09);
	bal(0, -16'sh00C8, 16'h08FC, 5'h00);
	$display("balance test done");
	for (i = 0; i < 61000 && learning_active_flag_o !== 1'b1; i = i + 1)
		step(1);
	chk(learning_active_flag_o, 1);
	$display("interval test done");
	end_of_test;
end
endmodule // supercap_learn_balance_ctrl_tb_top
bind supercap_learn_balance_ctrl supercap_learn_balance_ctrl_checker #(
	.NCAP(NCAP), .SEC_CYCLES(SEC_CYCLES))
	supercap_learn_balance_ctrl_checker_inst (.*);
